// file: design/ncl_top.v
// NCO control load port with phase path, input sample path and multiplier
`timescale 1ns/100ps
`include "ncl_regs.vh"
module ncl_top (
    input  wire                    mclk_i,
    input  wire                    nrst_i,
    input  wire [`NCL_CW_W-1:0]    control_word_bus_i,
    input  wire [1:0]              destination_select_i,
    input  wire                    unit_sel_n_i,
    input  wire                    write_strobe_n_i,
    input  wire                    phase_reg_load_en_n_i,
    input  wire                    offset_freq_load_en_n_i,
    input  wire                    center_freq_load_en_n_i,
    input  wire                    phase_acc_advance_en_n_i,
    input  wire                    time_interval_load_en_n_i,
    input  wire                    input_sample_load_en_n_i,
    input  wire [`NCL_IN_W-1:0]    real_in_i,
    input  wire [`NCL_IN_W-1:0]    imag_in_i,
    input  wire                    sample_valid_i,
    output wire                    sample_ready_o,
    input  wire [`NCL_ADDR_W-1:0]  reg_addr_i,
    input  wire [`NCL_CW_W-1:0]    reg_wdata_i,
    input  wire                    reg_wr_i,
    input  wire                    reg_rd_i,
    output reg  [`NCL_CW_W-1:0]    reg_rdata_o,
    output reg  [`NCL_OUT_W-1:0]   real_out_o,
    output reg  [`NCL_OUT_W-1:0]   imag_out_o,
    output reg                     out_valid_o
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Coarse triangle approximation of cosine over a 16-bit angle
    function [`NCL_TRIG_W-1:0] tri_cos;
        input [`NCL_TRIG_W-1:0] ang;
        reg   [`NCL_TRIG_W-1:0] fold;
        begin
            fold    = ang[15] ? ~ang : ang;
            tri_cos = {fold[14:0], 1'b0} ^ 16'h8000;
        end
    endfunction

    function [`NCL_OUT_W-1:0] scale_prod;
        input [`NCL_IN_W+`NCL_TRIG_W-1:0] p;
        begin
            scale_prod = p[`NCL_IN_W+`NCL_TRIG_W-2 -: `NCL_OUT_W];
        end
    endfunction

    // Carry dropped on purpose: phase wraps modulo 2^32
    function [`NCL_PH_W-1:0] add_wrap;
        input [`NCL_PH_W-1:0] a;
        input [`NCL_PH_W-1:0] b;
        begin
            add_wrap = a + b;
        end
    endfunction

    // Full-width signed product, scaling happens later
    function signed [`NCL_IN_W+`NCL_TRIG_W-1:0] smul;
        input signed [`NCL_IN_W-1:0]   s;
        input signed [`NCL_TRIG_W-1:0] t;
        begin
            smul = s * t;
        end
    endfunction

    // Top bits of a 19-bit input register, zero padded
    function [`NCL_CW_W-1:0] upper_lane;
        input [`NCL_IN_W-1:0] v;
        begin
            upper_lane = {13'h0, v[18:16]};
        end
    endfunction

    // ----------------------------------------------------------------
    // Strobe-written control registers
    // ----------------------------------------------------------------
    // Control words load on the rising edge of the strobe itself.
    // Without a second clock domain this is detected by sampling the
    // strobe on the main clock, so the strobe must stay low a cycle.
    reg                       wr_n_q;
    reg  [`NCL_PH_W-1:0]      phase_cw_q;
    reg  [`NCL_PH_W-1:0]      freq_cw_q;
    wire                      wr_rise;

    assign wr_rise = write_strobe_n_i & ~wr_n_q & ~unit_sel_n_i;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_n_q     <= 1'b1;
            phase_cw_q <= 32'h00000000;
            freq_cw_q  <= 32'h00000000;
        end else begin
            wr_n_q <= write_strobe_n_i;
            if (wr_rise) begin
                case (destination_select_i)
                    `NCL_DST_PH_LO: phase_cw_q[15:0]  <= control_word_bus_i;
                    `NCL_DST_PH_HI: phase_cw_q[31:16] <= control_word_bus_i;
                    `NCL_DST_FQ_LO: freq_cw_q[15:0]   <= control_word_bus_i;
                    `NCL_DST_FQ_HI: freq_cw_q[31:16]  <= control_word_bus_i;
                    default:        freq_cw_q         <= freq_cw_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered enables
    // ----------------------------------------------------------------
    reg en_ph_n_q;
    reg en_of_n_q;
    reg en_cf_n_q;
    reg en_pa_n_q;
    reg en_ti_n_q;
    reg en_in_n_q;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_ph_n_q <= 1'b1;
            en_of_n_q <= 1'b1;
            en_cf_n_q <= 1'b1;
            en_pa_n_q <= 1'b1;
            en_ti_n_q <= 1'b1;
            en_in_n_q <= 1'b1;
        end else begin
            en_ph_n_q <= phase_reg_load_en_n_i;
            en_of_n_q <= offset_freq_load_en_n_i;
            en_cf_n_q <= center_freq_load_en_n_i;
            en_pa_n_q <= phase_acc_advance_en_n_i;
            en_ti_n_q <= time_interval_load_en_n_i;
            en_in_n_q <= input_sample_load_en_n_i;
        end
    end

    // ----------------------------------------------------------------
    // Phase and frequency path
    // ----------------------------------------------------------------
    reg  [`NCL_PH_W-1:0]  phase_q;
    reg  [`NCL_PH_W-1:0]  offset_q;
    reg  [`NCL_PH_W-1:0]  center_q;
    reg  [`NCL_PH_W-1:0]  pacc_q;
    reg  [`NCL_PH_W-1:0]  time_q;
    wire [`NCL_PH_W-1:0]  freq_sum;
    wire [`NCL_TRIG_W-1:0] angle;

    // Sums drop their carry: modulo 2^32 for the frequency, 2^16 for the angle
    assign freq_sum = add_wrap(center_q, offset_q);
    assign angle    = pacc_q[31:16] + phase_q[31:16];

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q  <= 32'h00000000;
            offset_q <= 32'h00000000;
            center_q <= 32'h00000000;
            pacc_q   <= 32'h00000000;
            time_q   <= 32'h00000000;
        end else begin
            // Each loads a cycle after its enable pin was seen low
            if (!en_ph_n_q) begin
                phase_q <= phase_cw_q;
            end
            if (!en_of_n_q) begin
                offset_q <= freq_cw_q;
            end
            if (!en_cf_n_q) begin
                center_q <= freq_cw_q;
            end
            if (!en_pa_n_q) begin
                pacc_q <= add_wrap(pacc_q, freq_sum);
            end
            if (!en_ti_n_q) begin
                time_q <= add_wrap(time_q, freq_cw_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Input sample path through FIFO
    // ----------------------------------------------------------------
    wire [2*`NCL_IN_W-1:0] fifo_dout;
    wire                   fifo_valid;
    wire                   take;
    reg  [`NCL_IN_W-1:0]   real_input_reg_q;
    reg  [`NCL_IN_W-1:0]   imag_input_reg_q;

    // Samples wait in the FIFO until the registered enable lets them in
    assign take = fifo_valid & ~en_in_n_q;

    ncl_fifo #(
        .WIDTH (2*`NCL_IN_W),
        .DEPTH (`NCL_FIFO_DEPTH),
        .AW    (`NCL_FIFO_AW)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .nrst_i      (nrst_i),
        .in_data_i   ({real_in_i, imag_in_i}),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_dout),
        .out_valid_o (fifo_valid),
        .out_ready_i (~en_in_n_q)
    );

    reg load_q;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            real_input_reg_q <= 19'h00000;
            imag_input_reg_q <= 19'h00000;
            load_q           <= 1'b0;
        end else begin
            load_q <= take;
            if (take) begin
                real_input_reg_q <= fifo_dout[2*`NCL_IN_W-1:`NCL_IN_W];
                imag_input_reg_q <= fifo_dout[`NCL_IN_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Complex multiply and accumulate
    // ----------------------------------------------------------------
    reg                       acc_mode_q;
    wire signed [15:0]        cosv;
    wire signed [15:0]        sinv;
    wire signed [34:0]        rr;
    wire signed [34:0]        ii;
    wire signed [34:0]        ri;
    wire signed [34:0]        ir;
    wire [`NCL_OUT_W-1:0]     re_p;
    wire [`NCL_OUT_W-1:0]     im_p;

    assign cosv = tri_cos(angle);
    assign sinv = tri_cos(angle - 16'h4000);
    // Angle holds while the accumulator and phase load enables are off
    assign rr   = smul(real_input_reg_q, cosv);
    assign ii   = smul(imag_input_reg_q, sinv);
    assign ri   = smul(real_input_reg_q, sinv);
    assign ir   = smul(imag_input_reg_q, cosv);
    assign re_p = scale_prod(rr - ii);
    assign im_p = scale_prod(ri + ir);

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            real_out_o  <= 20'h00000;
            imag_out_o  <= 20'h00000;
            out_valid_o <= 1'b0;
        end else begin
            out_valid_o <= load_q;
            if (load_q) begin
                real_out_o <= acc_mode_q ? real_out_o + re_p : re_p;
                imag_out_o <= acc_mode_q ? imag_out_o + im_p : im_p;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    reg  [`NCL_CW_W-1:0]  rdata_d;
    wire [`NCL_CW_W-1:0]  status_w;

    // Enable copies as last seen, one bit per target
    assign status_w = {10'h0, en_in_n_q, en_ti_n_q, en_pa_n_q,
                       en_cf_n_q, en_of_n_q, en_ph_n_q};

    // Idle cycles return zero so stale data never lingers on the bus
    always @* begin
        rdata_d = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `NCL_A_CTRL:    rdata_d = {15'h0, acc_mode_q};
                `NCL_A_CW_LO:   rdata_d = freq_cw_q[15:0];
                `NCL_A_CW_HI:   rdata_d = freq_cw_q[31:16];
                `NCL_A_PACC_LO: rdata_d = pacc_q[15:0];
                `NCL_A_PACC_HI: rdata_d = pacc_q[31:16];
                `NCL_A_REAL_LO: rdata_d = real_input_reg_q[15:0];
                `NCL_A_REAL_HI: rdata_d = upper_lane(real_input_reg_q);
                `NCL_A_IMAG_LO: rdata_d = imag_input_reg_q[15:0];
                `NCL_A_IMAG_HI: rdata_d = upper_lane(imag_input_reg_q);
                `NCL_A_STAT:    rdata_d = status_w;
                `NCL_A_TIME_LO: rdata_d = time_q[15:0];
                `NCL_A_TIME_HI: rdata_d = time_q[31:16];
                default:        rdata_d = 16'h0000;
            endcase
        end
    end

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_mode_q  <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_rdata_o <= rdata_d;
            if (reg_wr_i && reg_addr_i == `NCL_A_CTRL) begin
                acc_mode_q <= reg_wdata_i[`NCL_CTRL_ACC];
            end
        end
    end
endmodule

// file: design/ncl_regs.vh
// Constants for the NCO control load port
`ifndef NCL_REGS_VH
`define NCL_REGS_VH
// Overview of operation
// - Control words arrive on a 16-bit bus whose bit 15 is the most significant bit.
// - A write strobe with unit select low stores the control word in the register named by the destination select.
// - All other registers change only on a rising main clock edge and only when their own enable is active; enable copies,
//   the strobe copy, load_q, out_valid_o and reg_rdata_o load on every edge.
// - The phase load enable is registered; while the registered copy is low the phase register loads.
// - The offset frequency enable is registered; while the registered copy is low the offset register loads.
// - The center frequency enable is registered; while the registered copy is low the center register loads.
// - The accumulator enable is registered; the phase accumulator advances only while it is low.
// - The time interval enable is registered; the time accumulator takes data only while it is low.
// - The input sample enable is registered; real and imaginary input registers load together.
// - Phase is carried at 32 bits and wraps modulo two to the thirty-second; the angle, taken from the top 16 bits, wraps modulo two to the sixteenth.
// - The input vector is multiplied by cosine and sine, optionally accumulated, giving two 20-bit results.
`define NCL_CW_W        16
`define NCL_PH_W        32
`define NCL_IN_W        19
`define NCL_OUT_W       20
`define NCL_TRIG_W      16
// Destination select codes
`define NCL_DST_PH_LO   2'h0
`define NCL_DST_PH_HI   2'h1
`define NCL_DST_FQ_LO   2'h2
`define NCL_DST_FQ_HI   2'h3
// Port register addresses
`define NCL_ADDR_W      4
`define NCL_A_CTRL      4'h0
`define NCL_A_CW_LO     4'h1
`define NCL_A_CW_HI     4'h2
`define NCL_A_PACC_LO   4'h3
`define NCL_A_PACC_HI   4'h4
`define NCL_A_REAL_LO   4'h5
`define NCL_A_REAL_HI   4'h6
`define NCL_A_IMAG_LO   4'h7
`define NCL_A_IMAG_HI   4'h8
`define NCL_A_STAT      4'h9
`define NCL_A_TIME_LO   4'hA
`define NCL_A_TIME_HI   4'hB
// Control register fields
`define NCL_CTRL_ACC    0
`define NCL_CTRL_RST    16'h0000
`define NCL_FIFO_DEPTH  8
`define NCL_FIFO_AW     3
`endif

// file: design/ncl_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ncl_fifo #(
    parameter WIDTH = 38,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk_i,
    input  wire             nrst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge mclk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            // Depth is a power of two, so the pointers wrap by themselves
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// file: dv/ncl_top_chk.sv
// Port assertions for the NCO control load port
`timescale 1ns/100ps
module ncl_top_chk (
    input wire        mclk_i,
    input wire        nrst_i,
    input wire        phase_reg_load_en_n_i,
    input wire        offset_freq_load_en_n_i,
    input wire        center_freq_load_en_n_i,
    input wire        phase_acc_advance_en_n_i,
    input wire        time_interval_load_en_n_i,
    input wire        input_sample_load_en_n_i,
    input wire        sample_valid_i,
    input wire        sample_ready_o,
    input wire [3:0]  reg_addr_i,
    input wire        reg_rd_i,
    input wire [15:0] reg_rdata_o,
    input wire [19:0] real_out_o,
    input wire [19:0] imag_out_o,
    input wire        out_valid_o
);
    wire [5:0] en_n = {input_sample_load_en_n_i, time_interval_load_en_n_i,
        phase_acc_advance_en_n_i, center_freq_load_en_n_i,
        offset_freq_load_en_n_i, phase_reg_load_en_n_i};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ----
    // Assertions
    // ----
    chk_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside read");
    chk_status_copy: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == 4'h9 |-> reg_rdata_o == {10'h000, $past(en_n, 2)})
        else $error("enable copies wrong");
    chk_unmapped_zero: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) > 4'hB |-> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    chk_ready_reset: assert property (
        $rose(nrst_i) |-> sample_ready_o) else $error("not ready after reset");
    chk_ready_fall: assert property (
        $fell(sample_ready_o) |-> $past(sample_valid_i)) else $error("ready fell without push");
    chk_ready_rise: assert property (
        $rose(sample_ready_o) |-> !$past(input_sample_load_en_n_i, 2))
        else $error("ready rose without pop");
    chk_valid_cause: assert property (
        out_valid_o |-> !$past(input_sample_load_en_n_i, 3) || !$past(input_sample_load_en_n_i, 4))
        else $error("result without input enable");
    chk_out_stable: assert property (
        !out_valid_o |-> $stable(real_out_o) && $stable(imag_out_o))
        else $error("result changed without valid");
    cover property (out_valid_o);
    cover property (!sample_ready_o);
    cover property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h9);
endmodule

// file: dv/ncl_src.sv
// Sample source model feeding the input FIFO
`timescale 1ns/100ps
module ncl_src (
    input  wire         mclk_i,
    input  wire         ready_i,
    output logic [18:0] real_o,
    output logic [18:0] imag_o,
    output logic        valid_o
);
    initial begin
        real_o = 19'h00000;
        imag_o = 19'h7FFFF;
        valid_o = 1'b0;
    end
    // Valid and data held until ready is seen at an edge
    task automatic send(input logic [18:0] r, input logic [18:0] i, input int bound,
                        output bit ok);
        ok = 1'b0;
        real_o <= r;
        imag_o <= i;
        valid_o <= 1'b1;
        for (int n = 0; n < bound && !ok; n++) begin
            @(posedge mclk_i);
            ok = ready_i;
        end
    endtask
    // Released lines flip so stale data never repeats
    task automatic idle();
        valid_o <= 1'b0;
        real_o <= ~real_o;
        imag_o <= ~imag_o;
    endtask
endmodule

// file: dv/ncl_top_bench.sv
// Self-checking bench for the NCO control load port
`timescale 1ns/100ps
`include "ncl_regs.vh"
`define NCL_CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module ncl_top_bench;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [15:0] cw_bus = 16'h0000;
    logic [1:0]  cw_dst = 2'h0;
    logic        cs_n   = 1'b1;
    logic        wr_n   = 1'b1;
    logic [5:0]  en_n   = 6'h3F;
    logic [3:0]  addr   = 4'h0;
    logic [15:0] wdata  = 16'h0000;
    logic        wr     = 1'b0;
    logic        rd     = 1'b0;
    wire  [18:0] s_re;
    wire  [18:0] s_im;
    wire         s_valid;
    wire         s_ready;
    wire  [15:0] rdata;
    wire  [19:0] r_out;
    wire  [19:0] i_out;
    wire         o_valid;
    int          err_count = 0;
    int          check_count = 0;
    bit          ok;
    int          n_out;
    always #25 mclk_i = ~mclk_i;
    ncl_src u_ncl_src (.mclk_i(mclk_i), .ready_i(s_ready), .real_o(s_re), .imag_o(s_im),
        .valid_o(s_valid));
    ncl_top u_ncl_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .control_word_bus_i(cw_bus),
        .destination_select_i(cw_dst), .unit_sel_n_i(cs_n), .write_strobe_n_i(wr_n),
        .phase_reg_load_en_n_i(en_n[0]), .offset_freq_load_en_n_i(en_n[1]),
        .center_freq_load_en_n_i(en_n[2]), .phase_acc_advance_en_n_i(en_n[3]),
        .time_interval_load_en_n_i(en_n[4]), .input_sample_load_en_n_i(en_n[5]),
        .real_in_i(s_re), .imag_in_i(s_im), .sample_valid_i(s_valid),
        .sample_ready_o(s_ready), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .real_out_o(r_out), .imag_out_o(i_out),
        .out_valid_o(o_valid));
    // ----
    // Tasks
    // ----
    task automatic close_out();
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 `NCL_CHK(rdata, exp)
    endtask
    task automatic cw(input logic [1:0] d, input logic [15:0] w, input logic sel_n);
        @(posedge mclk_i);
        cw_bus <= w;
        cw_dst <= d;
        cs_n <= sel_n;
        wr_n <= 1'b0;
        @(posedge mclk_i);
        wr_n <= 1'b1;
        @(posedge mclk_i);
        cs_n <= 1'b1;
        cw_bus <= ~w;
    endtask
    // Pin low for n edges gives n loads, one edge late
    task automatic en_pulse(input int b, input int n);
        @(posedge mclk_i);
        en_n[b] <= 1'b0;
        repeat (n) @(posedge mclk_i);
        en_n[b] <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic t_ports();
        reg_chk(`NCL_A_STAT, 16'h003F);
        reg_chk(`NCL_A_PACC_LO, 16'h0000);
        for (int d = 0; d < 4; d++) begin
            cw(d[1:0], 16'(16'h1111 * (d + 1)), 1'b0);
        end
        reg_chk(`NCL_A_CW_LO, 16'h3333);
        reg_chk(`NCL_A_CW_HI, 16'h4444);
        cw(`NCL_DST_FQ_LO, 16'hFFFF, 1'b1);
        reg_chk(`NCL_A_CW_LO, 16'h3333);
        reg_wr(`NCL_A_CTRL, 16'h0001);
        reg_chk(`NCL_A_CTRL, 16'h0001);
        reg_wr(`NCL_A_CTRL, 16'h0000);
        reg_wr(4'hD, 16'hBEEF);
        reg_chk(4'hD, 16'h0000);
    endtask
    task automatic t_enables();
        en_pulse(0, 1);
        en_pulse(2, 1);
        en_pulse(1, 1);
        en_pulse(3, 1);
        reg_chk(`NCL_A_PACC_LO, 16'h6666);
        reg_chk(`NCL_A_PACC_HI, 16'h8888);
        en_pulse(3, 1);
        repeat (5) @(posedge mclk_i);
        reg_chk(`NCL_A_PACC_LO, 16'hCCCC);
        reg_chk(`NCL_A_PACC_HI, 16'h1110);
        en_pulse(4, 1);
        reg_chk(`NCL_A_TIME_LO, 16'h3333);
        reg_chk(`NCL_A_TIME_HI, 16'h4444);
    endtask
    // Fill the FIFO with the input enable off, then drain it
    task automatic t_samples();
        n_out = 0;
        for (int k = 0; k < 8; k++) begin
            u_ncl_src.send(19'(19'h00010 + k), 19'(19'h70000 + k), 50, ok);
            `NCL_CHK(ok, 1'b1)
        end
        u_ncl_src.send(19'h00055, 19'h70055, 4, ok);
        `NCL_CHK(ok, 1'b0)
        u_ncl_src.idle();
        en_n[5] <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            @(posedge mclk_i);
            #1 n_out += (o_valid === 1'b1);
        end
        en_n[5] <= 1'b1;
        `NCL_CHK(n_out, 8)
        `NCL_CHK(s_ready, 1'b1)
        reg_chk(`NCL_A_REAL_LO, 16'h0017);
        reg_chk(`NCL_A_IMAG_LO, 16'h0007);
        reg_chk(`NCL_A_IMAG_HI, 16'h0007);
    endtask
    // One sample through the FIFO, waits for its result pulse
    task automatic feed(input logic [18:0] r, input logic [18:0] i);
        u_ncl_src.send(r, i, 20, ok);
        `NCL_CHK(ok, 1'b1)
        u_ncl_src.idle();
        en_n[5] <= 1'b0;
        ok = 1'b0;
        for (int c = 0; c < 20 && !ok; c++) begin
            @(posedge mclk_i);
            #1 ok = (o_valid === 1'b1);
        end
        @(posedge mclk_i);
        en_n[5] <= 1'b1;
        `NCL_CHK(ok, 1'b1)
    endtask
    // Angle is frozen here, so a repeated sample gives the same product
    task automatic t_accum();
        logic [19:0] r1;
        logic [19:0] i1;
        feed(19'h00000, 19'h00000);
        `NCL_CHK(r_out, 20'h00000)
        `NCL_CHK(i_out, 20'h00000)
        feed(19'h01234, 19'h7EDCC);
        r1 = r_out;
        i1 = i_out;
        reg_wr(`NCL_A_CTRL, 16'h0001);
        feed(19'h01234, 19'h7EDCC);
        `NCL_CHK(r_out, 20'(r1 + r1))
        `NCL_CHK(i_out, 20'(i1 + i1))
        reg_wr(`NCL_A_CTRL, 16'h0000);
    endtask
    initial begin
        #3000000;
        err_count++;
        $display("ERROR %0t: run timed out", $time);
        close_out();
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_ports();
        t_enables();
        t_samples();
        t_accum();
        close_out();
    end
endmodule
bind ncl_top ncl_top_chk u_ncl_top_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .phase_reg_load_en_n_i(phase_reg_load_en_n_i),
    .offset_freq_load_en_n_i(offset_freq_load_en_n_i),
    .center_freq_load_en_n_i(center_freq_load_en_n_i),
    .phase_acc_advance_en_n_i(phase_acc_advance_en_n_i),
    .time_interval_load_en_n_i(time_interval_load_en_n_i),
    .input_sample_load_en_n_i(input_sample_load_en_n_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .real_out_o(real_out_o), .imag_out_o(imag_out_o),
    .out_valid_o(out_valid_o));
